// ---- hw/pcs_params.svh ----
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// =====================================================================
// register offsets on the plain register port
`define PCS_OFS_PC_LOW 8'h00
`define PCS_OFS_PC_LATCH 8'h01

// =====================================================================
// widths and field positions
`define PCS_PC_W 13
`define PCS_LATCH_W 5
`define PCS_LIT_W 11
`define PCS_STACK_DEPTH 8
`define PCS_PTR_W 3
`define PCS_LATCH_PAGE_LO 3
`define PCS_LATCH_PAGE_HI 4

// =====================================================================
// reset values and fixed addresses
`define PCS_PC_RESET 13'h0000
`define PCS_LATCH_RESET 5'h00
`define PCS_INT_VECTOR 13'h0004

`endif

// ---- hw/pcs_pkg.sv ----
package pcs_pkg;

  // =====================================================================
  // sequencing requests from the decode and execute logic
  typedef enum logic [2:0] {
    PCS_OP_ADVANCE = 3'b000,
    PCS_OP_JUMP = 3'b001,
    PCS_OP_CALL = 3'b010,
    PCS_OP_RETURN = 3'b011,
    PCS_OP_RET_LIT = 3'b100,
    PCS_OP_RET_INT = 3'b101,
    PCS_OP_INTERRUPT = 3'b110
  } pcs_op_type;

endpackage : pcs_pkg

// ---- hw/pcs_stack.sv ----
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_stack (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // push and pop, never both in one cycle
  input wire logic push,
  input wire logic pop,
  input wire logic [`PCS_PC_W-1:0] push_data,
  // entry last pushed
  output logic [`PCS_PC_W-1:0] top_data
);

  // =====================================================================
  // storage and pointer
  logic [`PCS_PC_W-1:0] mem_ff [0:`PCS_STACK_DEPTH-1];
  logic [`PCS_PTR_W-1:0] ptr_ff;
  logic [`PCS_PTR_W-1:0] ptr_prev;

  // pointer arithmetic wraps by width, so no overflow or underflow flag
  assign ptr_prev = ptr_ff - 3'h1;
  assign top_data = mem_ff[ptr_prev];

  // pointer is kept internal, software has no path to it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_ff <= 3'h0;
    end else if (push) begin
      ptr_ff <= ptr_ff + 3'h1;
    end else if (pop) begin
      ptr_ff <= ptr_prev;
    end
  end

  // ninth push lands on the slot of the first
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[ptr_ff] <= push_data;
    end
  end

endmodule : pcs_stack

// ---- hw/pcs_target.sv ----
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_target (
  // page select latch and instruction literal
  input wire logic [`PCS_LATCH_W-1:0] latch,
  input wire logic [`PCS_LIT_W-1:0] literal,
  // full branch address
  output logic [`PCS_PC_W-1:0] target
);

  // =====================================================================
  // branch address forming
  // the top latch bit is not a page bit here, the top counter bit is 0
  function automatic logic [`PCS_PC_W-1:0] pcs_branch_addr(
    input logic [`PCS_LATCH_W-1:0] l,
    input logic [`PCS_LIT_W-1:0] lit
  );
    pcs_branch_addr = {1'b0, l[`PCS_LATCH_PAGE_LO], lit};
  endfunction : pcs_branch_addr

  assign target = pcs_branch_addr(latch, literal);

endmodule : pcs_target

// ---- hw/pcs_core.sv ----
// Operation
// - a 13-bit counter gives the fetch address; its low byte is a software register
// - upper five counter bits are hidden; software writes them only via the high latch
// - writing the low byte loads it and copies latch bits 4:0 upward
// - jump and call take 11 literal bits plus latch bit 3 as page, with the top counter bit 0
// - a call pushes the full 13-bit return address while loading the target
// - an interrupt branch pushes the current counter like a call
// - the three return kinds pop the top entry into the whole counter
// - eight 13-bit entries, outside memory maps, pointer invisible to software
// - pushes and pops never touch the high latch
// - circular stack, no overflow flag; ninth push overwrites the first
// - latch bit 4 is ignored for paging and should not hold data
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sequencing requests
  input wire logic op_valid,
  input wire pcs_pkg::pcs_op_type op_code,
  input wire logic [`PCS_LIT_W-1:0] op_literal,
  // fetch side
  output logic [`PCS_PC_W-1:0] fetch_addr
);

  // =====================================================================
  // state
  logic [`PCS_PC_W-1:0] pc_ff;
  logic [`PCS_PC_W-1:0] nxt_pc;
  logic [`PCS_LATCH_W-1:0] latch_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [`PCS_PC_W-1:0] branch_addr;
  logic [`PCS_PC_W-1:0] stack_top;
  logic push;
  logic pop;
  logic [`PCS_PC_W-1:0] push_data;
  logic wr_pc_low;
  logic wr_latch;

  // =====================================================================
  // register decode
  always_comb begin
    wr_pc_low = 1'b0;
    wr_latch = 1'b0;
    if (reg_wr && reg_addr == `PCS_OFS_PC_LOW) begin
      wr_pc_low = 1'b1;
    end else if (reg_wr && reg_addr == `PCS_OFS_PC_LATCH) begin
      wr_latch = 1'b1;
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd && reg_addr == `PCS_OFS_PC_LOW) begin
      nxt_rdata = pc_ff[7:0];
    end else if (reg_rd && reg_addr == `PCS_OFS_PC_LATCH) begin
      nxt_rdata = {3'h0, latch_ff};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // =====================================================================
  // high latch, written only by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      latch_ff <= `PCS_LATCH_RESET;
    end else if (wr_latch) begin
      latch_ff <= reg_wdata[`PCS_LATCH_W-1:0];
    end
  end

  // =====================================================================
  // stack control
  // the pc held here is already the address after the branching
  // instruction, so it is the return address as it stands
  always_comb begin
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_ff;
    if (op_valid) begin
      case (op_code)
        pcs_pkg::PCS_OP_CALL: begin
          push = 1'b1;
        end
        pcs_pkg::PCS_OP_INTERRUPT: begin
          push = 1'b1;
        end
        pcs_pkg::PCS_OP_RETURN,
        pcs_pkg::PCS_OP_RET_LIT,
        pcs_pkg::PCS_OP_RET_INT: begin
          pop = 1'b1;
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end
  end

  pcs_stack u_stack (
    .core_clk(core_clk),
    .srst(srst),
    .push(push),
    .pop(pop),
    .push_data(push_data),
    .top_data(stack_top)
  );

  // page bits are taken as they stand; software sets them beforehand
  pcs_target u_target (
    .latch(latch_ff),
    .literal(op_literal),
    .target(branch_addr)
  );

  // =====================================================================
  // next counter: a branch request wins over a low-byte write
  always_comb begin
    nxt_pc = pc_ff;
    if (wr_pc_low) begin
      nxt_pc = {latch_ff, reg_wdata};
    end
    if (op_valid) begin
      case (op_code)
        pcs_pkg::PCS_OP_ADVANCE: begin
          if (!wr_pc_low) begin
            nxt_pc = pc_ff + 13'h0001;
          end
        end
        pcs_pkg::PCS_OP_JUMP,
        pcs_pkg::PCS_OP_CALL: begin
          nxt_pc = branch_addr;
        end
        pcs_pkg::PCS_OP_RETURN,
        pcs_pkg::PCS_OP_RET_LIT,
        pcs_pkg::PCS_OP_RET_INT: begin
          nxt_pc = stack_top;
        end
        pcs_pkg::PCS_OP_INTERRUPT: begin
          nxt_pc = `PCS_INT_VECTOR;
        end
        default: begin
          nxt_pc = pc_ff;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc_ff <= `PCS_PC_RESET;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // =====================================================================
  // outputs straight from flip-flops
  assign fetch_addr = pc_ff;
  assign reg_rdata = rdata_ff;

endmodule : pcs_core

// ---- sim/pcs_core_assertions.sv ----
`timescale 1ns/1ps
// =========
// checker on the sequencer ports
module pcs_core_assertions (
  // clock, reset and register port
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // requests and fetch side
  input wire logic op_valid,
  input wire pcs_pkg::pcs_op_type op_code,
  input wire logic [10:0] op_literal,
  input wire logic [12:0] fetch_addr
);
  logic [4:0] lat_ff;
  wire [7:0] pc_lo = fetch_addr[7:0];
  // shadow latch follows software writes only, so stack traffic cannot move it
  always_ff @(posedge core_clk) begin
    if (srst) lat_ff <= 5'h00;
    else if (reg_wr && reg_addr == 8'h01) lat_ff <= reg_wdata[4:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_adv;
    op_valid && op_code == pcs_pkg::PCS_OP_ADVANCE && !reg_wr
    |=> fetch_addr == $past(fetch_addr) + 13'h0001;
  endproperty
  a_adv: assert property (p_adv) else $error("no advance");
  property p_hold;
    !op_valid && !reg_wr |=> $stable(fetch_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("pc moved");
  property p_br;
    op_valid && op_code inside {pcs_pkg::PCS_OP_JUMP, pcs_pkg::PCS_OP_CALL}
    |=> fetch_addr == {1'b0, $past(lat_ff[3]), $past(op_literal)};
  endproperty
  a_br: assert property (p_br) else $error("bad target");
  property p_wlo;
    reg_wr && reg_addr == 8'h00 && !(op_valid && op_code != pcs_pkg::PCS_OP_ADVANCE)
    |=> fetch_addr == {$past(lat_ff), $past(reg_wdata)};
  endproperty
  a_wlo: assert property (p_wlo) else $error("bad low write");
  property p_int;
    op_valid && op_code == pcs_pkg::PCS_OP_INTERRUPT |=> fetch_addr == 13'h0004;
  endproperty
  a_int: assert property (p_int) else $error("bad vector");
  property p_cr;
    op_valid && op_code == pcs_pkg::PCS_OP_CALL ##1 op_valid && op_code == pcs_pkg::PCS_OP_RETURN
    |=> fetch_addr == $past(fetch_addr, 2);
  endproperty
  a_cr: assert property (p_cr) else $error("bad return");
  property p_rlo;
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(pc_lo);
  endproperty
  a_rlo: assert property (p_rlo) else $error("bad low read");
  property p_rlat;
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == {3'h0, $past(lat_ff)};
  endproperty
  a_rlat: assert property (p_rlat) else $error("bad latch read");
  property p_rz;
    !(reg_rd && reg_addr <= 8'h01) |=> reg_rdata == 8'h00;
  endproperty
  a_rz: assert property (p_rz) else $error("data not zero");
endmodule : pcs_core_assertions

bind pcs_core pcs_core_assertions u_chk (.core_clk(core_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
  .op_literal(op_literal), .fetch_addr(fetch_addr));

// ---- sim/pcs_dec_model.sv ----
`timescale 1ns/1ps
// =========
// decode side issuing sequencing requests
module pcs_dec_model (
  // clock
  input wire logic core_clk,
  // requests
  output logic op_valid,
  output pcs_pkg::pcs_op_type op_code,
  output logic [10:0] op_literal
);
  // quiet at time zero
  initial begin
    op_valid = 1'b0;
    op_code = pcs_pkg::PCS_OP_ADVANCE;
    op_literal = 11'h000;
  end
  // caller sets page bits first; calling go twice gives back to back requests
  task automatic go(pcs_pkg::pcs_op_type c, logic [10:0] l);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_literal <= l;
  endtask : go
  // literal flips when idle so a stale value is never mistaken for a fresh one
  task automatic idle();
    @(posedge core_clk);
    op_valid <= 1'b0;
    op_literal <= ~op_literal;
  endtask : idle
endmodule : pcs_dec_model

// ---- sim/pcs_core_tb.sv ----
`timescale 1ns/1ps
// =========
// sequencer bench
module pcs_core_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic op_valid;
  pcs_pkg::pcs_op_type op_code;
  logic [10:0] op_literal;
  logic [12:0] fetch_addr;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  pcs_dec_model dec (.core_clk(core_clk), .op_valid(op_valid), .op_code(op_code),
    .op_literal(op_literal));
  pcs_core dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_code(op_code), .op_literal(op_literal), .fetch_addr(fetch_addr));
  // clock, and a watchdog well above the hundred or so cycles needed
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic c13(logic [12:0] e);
    total_checks++;
    if (fetch_addr !== e) begin
      num_errors++;
      $display("unexpected fetch_addr exp %h got %h", e, fetch_addr);
    end
  endtask : c13
  task automatic c8(logic [7:0] e);
    total_checks++;
    if (reg_rdata !== e) begin
      num_errors++;
      $display("unexpected reg_rdata exp %h got %h", e, reg_rdata);
    end
  endtask : c8
  // one cycle strobes; read data stands only in the cycle after the strobe
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 c8(e);
  endtask : rd
  task automatic op(pcs_pkg::pcs_op_type c, logic [10:0] l, logic [12:0] e);
    dec.go(c, l);
    dec.idle();
    #1 c13(e);
  endtask : op
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // main sequence; ring of nine pushes shows the first entry overwritten
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    #1 c13(13'h0000);
    rd(8'h01, 8'h00);
    wr(8'h01, 8'hFF);
    wr(8'h00, 8'h34);
    c13(13'h1F34);
    rd(8'h00, 8'h34);
    rd(8'h01, 8'h1F);
    wr(8'h00, 8'hFF);
    op(pcs_pkg::PCS_OP_ADVANCE, 11'h000, 13'h0000);
    wr(8'h01, 8'h18);
    op(pcs_pkg::PCS_OP_JUMP, 11'h123, 13'h0923);
    dec.go(pcs_pkg::PCS_OP_CALL, 11'h055);
    op(pcs_pkg::PCS_OP_RETURN, 11'h000, 13'h0923);
    for (int i = 0; i < 8; i++) op(pcs_pkg::PCS_OP_CALL, 11'(i), 13'h0800 + 13'(i));
    op(pcs_pkg::PCS_OP_INTERRUPT, 11'h000, 13'h0004);
    rd(8'h01, 8'h18);
    for (int j = 0; j < 9; j++) op(pcs_pkg::pcs_op_type'(3'(3 + j % 3)), 11'h000,
      13'h0800 + 13'((j == 8 ? 8 : 8 - j) - 1));
    // the unused code 7 is a stall, the counter must not move
    op(pcs_pkg::pcs_op_type'(3'h7), 11'h000, 13'h0807);
    // a low-byte write beats a plain advance in the same cycle
    fork
      wr(8'h00, 8'h40);
      op(pcs_pkg::PCS_OP_ADVANCE, 11'h000, 13'h1840);
    join
    // a branch beats a low-byte write in the same cycle
    fork
      wr(8'h00, 8'h77);
      op(pcs_pkg::PCS_OP_JUMP, 11'h011, 13'h0811);
    join
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h01, 8'h18);
    tally_and_finish();
  end
endmodule : pcs_core_tb
